// [src/eos_params.svh]
// ----------------------------------------------------------------
// constants of the emergency override supervisor
// ----------------------------------------------------------------
// What this block does
// [RULE_01] enter override when the assigned override input goes to zero
// [RULE_02] on entry raise the override alarm and show override in mode status
// [RULE_03] operator key clears the alarm; mode status keeps showing override
// [RULE_04] override digital output is active while override is in effect
// [RULE_05] during override every stop command, general enable too, is ignored
// [RULE_06] overvoltage and overcurrent faults still act and may auto-reset
// [RULE_07] override configuration resets to 0; 0 is off, 3 is reserved
// [RULE_08] configuration 1 raises the alarm, reference and control unchanged
// [RULE_09] configuration 2 forces speed reference to the maximum frequency limit
// [RULE_10] configuration 4 disables output pulses so the motor coasts
// [RULE_11] auto-reset field 0: critical faults reset only as general setting allows
// [RULE_12] auto-reset field 1: critical fault resets one second after detection
// [RULE_13] control option word is four bits, 0h to Fh, one option per bit
// [RULE_14] bit 0 clear turns slip compensation off while regenerating
// [RULE_15] software keeps bit 1 dead-time compensation set except maintenance
// [RULE_16] bit 2 set enables closed-loop output current stabilisation
// [RULE_17] bit 3 lowers switching frequency from alarm to fault temperature
// [RULE_18] current-reading frequency reduction wins over thermal reduction
// [RULE_19] override input is synchronised before use
// assumes: included by the package and the modules, definitions only
`ifndef EOS_PARAMS_SVH
`define EOS_PARAMS_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define EOS_ADDR_OVR_CFG 8'h00
`define EOS_ADDR_OVR_ARS 8'h04
`define EOS_ADDR_CTRL_OPT 8'h08
`define EOS_ADDR_STATUS 8'h0C
`define EOS_RST_OVR_CFG 16'h0000
`define EOS_RST_OVR_ARS 16'h0000
`define EOS_RST_CTRL_OPT 4'hB
// only the override input resets high: a reset must never read as an opened contact
`define EOS_PIN_RST_VAL 4'h1

// ----------------------------------------------------------------
// field values
// ----------------------------------------------------------------
`define EOS_CFG_OFF 16'h0000
`define EOS_CFG_ALARM 16'h0001
`define EOS_CFG_MAXREF 16'h0002
`define EOS_CFG_RESERVED 16'h0003
`define EOS_CFG_COAST 16'h0004
`define EOS_ARS_UNLIMITED 16'h0001
`define EOS_OPT_SLIP 0
`define EOS_OPT_DEADTIME 1
`define EOS_OPT_STAB 2
`define EOS_OPT_THERMAL 3
`define EOS_MODE_READY 4'h0
`define EOS_MODE_RUN 4'h1
`define EOS_MODE_FAULT 4'h2
`define EOS_MODE_OVERRIDE 4'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EOS_CLK_MHZ 250
`define EOS_AUTORESET_MS 1000
`define EOS_AUTORESET_CYCLES (`EOS_AUTORESET_MS * 1000 * `EOS_CLK_MHZ)
`define EOS_TMR_W 28
`define EOS_SYNC_W 4

`endif

// [src/eos_pkg.sv]
// types of the emergency override supervisor
// assumes: eos_params.svh on the include path
`include "eos_params.svh"
package eos_pkg;

  typedef enum logic [3:0] {
    EOS_MODE_READY = 4'b0000,
    EOS_MODE_RUN = 4'b0001,
    EOS_MODE_FAULT = 4'b0010,
    EOS_MODE_OVERRIDE = 4'b0011
  } eos_mode_e;

  typedef struct packed {
    logic [`EOS_SYNC_W-1:0] stage1;
    logic [`EOS_SYNC_W-1:0] stage2;
  } eos_sync_s;

  typedef struct packed {
    logic [`EOS_TMR_W-1:0] count;
    logic done;
  } eos_timer_s;

  typedef struct packed {
    logic [15:0] ovr_cfg;
    logic [15:0] ovr_ars;
    logic [3:0] ctrl_opt;
    logic override;
    logic alarm;
    logic fault;
    logic run;
    logic key_q;
    eos_mode_e mode;
    logic [15:0] speed;
    logic [7:0] swf;
    logic dph_wr;
    logic dph_rd;
    logic rd_wait;
    logic [7:0] addr;
    logic [31:0] hrdata;
  } eos_state_s;

endpackage

// [src/eos_sync.sv]
// two-stage synchroniser for the pin inputs
// assumes: inputs asynchronous to i_clk_sys
`timescale 1ns/1ps
`include "eos_params.svh"
module eos_sync
  import eos_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [`EOS_SYNC_W-1:0] i_async,
  input wire logic [`EOS_SYNC_W-1:0] i_rst_val,
  output logic [`EOS_SYNC_W-1:0] o_sync
);
  eos_sync_s st;
  eos_sync_s next_st;

  always_comb
  begin
    next_st.stage1 = i_async;
    next_st.stage2 = st.stage1;
  end

  // reset value of the pins is a constant at each instance
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st.stage1 <= i_rst_val;
      st.stage2 <= i_rst_val;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_sync = st.stage2;
endmodule // eos_sync

// [src/eos_autoreset.sv]
// delay timer for unlimited auto-reset of critical faults
// assumes: i_arm held high while a fault waits for its reset
`timescale 1ns/1ps
`include "eos_params.svh"
module eos_autoreset
  import eos_pkg::*;
#(
  parameter logic [`EOS_TMR_W-1:0] CYCLES = `EOS_TMR_W'(`EOS_AUTORESET_CYCLES)
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_arm,
  output logic o_done
);
  eos_timer_s st;
  eos_timer_s next_st;

  always_comb
  begin
    next_st.done = 1'b0;
    next_st.count = '0;
    if (i_arm && !st.done)
    begin
      if (st.count == CYCLES - `EOS_TMR_W'(1))
      begin
        next_st.done = 1'b1; // [RULE_12]
      end
      else
      begin
        next_st.count = st.count + `EOS_TMR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_done = st.done;
endmodule // eos_autoreset

// [src/eos_supervisor.sv]
// emergency override supervisor of the motor drive, with AHB-Lite registers
// assumes: one slave on the bus, hready is this hreadyout; fault and
// frequency inputs come from logic on i_clk_sys, keypad and DI pins do not
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "eos_params.svh"
module eos_supervisor
  import eos_pkg::*;
#(
  parameter logic [`EOS_TMR_W-1:0] AUTORESET_CYCLES = `EOS_TMR_W'(`EOS_AUTORESET_CYCLES)
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // pins
  input wire logic i_override_digital_input,
  input wire logic i_operator_key,
  input wire logic i_general_enable,
  input wire logic i_run_command,
  // drive logic on the same clock
  input wire logic i_dc_link_overvoltage_fault,
  input wire logic i_overcurrent_short_fault,
  input wire logic i_other_fault,
  input wire logic i_fault_reset,
  input wire logic i_general_autoreset_setting,
  input wire logic i_regenerating,
  input wire logic [15:0] i_speed_reference,
  input wire logic [15:0] i_maximum_frequency_limit,
  input wire logic [7:0] i_switching_frequency_setting,
  input wire logic [7:0] i_minimum_switching_frequency,
  input wire logic [7:0] i_temperature,
  input wire logic [7:0] i_overtemperature_alarm,
  input wire logic [7:0] i_overtemperature_fault,
  input wire logic i_current_read_freq_reduction,
  input wire logic [7:0] i_current_read_frequency,
  // outputs
  output logic o_override_alarm,
  output logic o_override_digital_output,
  output logic [3:0] o_operating_mode_status,
  output logic o_fault_active,
  output logic o_fault_autoreset,
  output logic o_run_enable,
  output logic o_pulse_enable,
  output logic [15:0] o_speed_reference,
  output logic [7:0] o_switching_frequency,
  output logic o_slip_comp_enable,
  output logic o_dead_time_comp_enable,
  output logic o_current_stab_enable
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // configuration values 0, 3 and anything above 4 leave the function off
  function automatic logic cfg_active(input logic [15:0] cfg);
    cfg_active = (cfg == `EOS_CFG_ALARM) || (cfg == `EOS_CFG_MAXREF) ||
      (cfg == `EOS_CFG_COAST);
  endfunction

  // linear fall from the set frequency at alarm level to the minimum at fault level
  function automatic logic [7:0] thermal_freq(input logic [7:0] fset,
    input logic [7:0] fmin, input logic [7:0] t, input logic [7:0] ta,
    input logic [7:0] tf);
    logic [15:0] span;
    span = 16'((fset - fmin) * (t - ta));
    if (t <= ta || tf <= ta || fset <= fmin)
      thermal_freq = fset;
    else if (t >= tf)
      thermal_freq = fmin;
    else
      thermal_freq = fset - 8'(span / {8'h00, tf - ta});
  endfunction

  function automatic eos_mode_e mode_of(input logic ovr, input logic flt,
    input logic run);
    if (ovr)
      mode_of = EOS_MODE_OVERRIDE;
    else if (flt)
      mode_of = EOS_MODE_FAULT;
    else if (run)
      mode_of = EOS_MODE_RUN;
    else
      mode_of = EOS_MODE_READY;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`EOS_SYNC_W-1:0] pins_s;
  logic ovr_in_s;
  logic key_s;
  logic gen_en_s;
  logic run_cmd_s;

  // input resets high so a reset never looks like an opened contact
  eos_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async({i_run_command, i_general_enable, i_operator_key,
      i_override_digital_input}),
    .i_rst_val(`EOS_PIN_RST_VAL),
    .o_sync(pins_s)
  ); // [RULE_19]

  assign ovr_in_s = pins_s[0];
  assign key_s = pins_s[1];
  assign gen_en_s = pins_s[2];
  assign run_cmd_s = pins_s[3];

  // ----------------------------------------------------------------
  // state and auto-reset timer
  // ----------------------------------------------------------------
  eos_state_s st;
  eos_state_s next_st;
  logic ar_done;
  logic ar_arm;
  logic ovr_req;
  logic key_edge;
  logic crit;
  logic flt_set;
  logic flt_clr;
  logic acc;

  assign ar_arm = st.override && st.fault && (st.ovr_ars == `EOS_ARS_UNLIMITED);

  eos_autoreset #(.CYCLES(AUTORESET_CYCLES)) u_autoreset (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_arm(ar_arm),
    .o_done(ar_done)
  );

  always_comb
  begin
    next_st = st;
    ovr_req = cfg_active(st.ovr_cfg) && !ovr_in_s; // [RULE_01] [RULE_07]
    key_edge = key_s && !st.key_q;
    crit = i_dc_link_overvoltage_fault || i_overcurrent_short_fault;
    next_st.key_q = key_s;
    next_st.override = ovr_req;
    // entry sets the alarm even if the key is pressed in the same cycle
    if (ovr_req && !st.override)
      next_st.alarm = 1'b1; // [RULE_02]
    else if (!ovr_req || key_edge)
      next_st.alarm = 1'b0; // [RULE_03]
    // other faults are inhibited during override, critical ones are not
    flt_set = crit || (i_other_fault && !st.override); // [RULE_06]
    if (st.override && st.ovr_ars == `EOS_ARS_UNLIMITED)
      flt_clr = ar_done; // [RULE_12]
    else if (st.override)
      flt_clr = i_general_autoreset_setting; // [RULE_11]
    else
      flt_clr = i_general_autoreset_setting || i_fault_reset;
    next_st.fault = flt_set || (st.fault && !flt_clr);
    // stop and general disable cannot drop run while in override
    if (ovr_req)
      next_st.run = st.run || run_cmd_s || (st.ovr_cfg == `EOS_CFG_MAXREF); // [RULE_05]
    else
      next_st.run = run_cmd_s && gen_en_s && !next_st.fault;
    next_st.mode = mode_of(next_st.override, next_st.fault, next_st.run); // [RULE_02]
    if (ovr_req && st.ovr_cfg == `EOS_CFG_MAXREF)
      next_st.speed = i_maximum_frequency_limit; // [RULE_09]
    else
      next_st.speed = i_speed_reference; // [RULE_08]
    if (i_current_read_freq_reduction)
      next_st.swf = i_current_read_frequency; // [RULE_18]
    else if (st.ctrl_opt[`EOS_OPT_THERMAL])
      next_st.swf = thermal_freq(i_switching_frequency_setting,
        i_minimum_switching_frequency, i_temperature, i_overtemperature_alarm,
        i_overtemperature_fault); // [RULE_17]
    else
      next_st.swf = i_switching_frequency_setting;
    // ------------------------------------------------------------
    // ahb-lite slave: writes zero wait, reads one wait state so a
    // read right after a write sees the new value
    // ------------------------------------------------------------
    if (st.dph_wr)
    begin
      case (st.addr)
        `EOS_ADDR_OVR_CFG: next_st.ovr_cfg = i_hwdata[15:0];
        `EOS_ADDR_OVR_ARS: next_st.ovr_ars = i_hwdata[15:0];
        `EOS_ADDR_CTRL_OPT: next_st.ctrl_opt = i_hwdata[3:0]; // [RULE_13]
        default: next_st.ovr_cfg = st.ovr_cfg;
      endcase
    end
    if (st.dph_rd && st.rd_wait)
    begin
      case (st.addr)
        `EOS_ADDR_OVR_CFG: next_st.hrdata = {16'h0000, st.ovr_cfg};
        `EOS_ADDR_OVR_ARS: next_st.hrdata = {16'h0000, st.ovr_ars};
        `EOS_ADDR_CTRL_OPT: next_st.hrdata = {28'h0000000, st.ctrl_opt};
        `EOS_ADDR_STATUS: next_st.hrdata = {24'h000000, ar_arm, st.fault,
          st.override, st.alarm, st.mode};
        default: next_st.hrdata = 32'h00000000;
      endcase
    end
    next_st.rd_wait = 1'b0;
    acc = i_hsel && i_hready && i_htrans[1];
    if (o_hreadyout)
    begin
      next_st.dph_wr = acc && i_hwrite;
      next_st.dph_rd = acc && !i_hwrite;
      next_st.rd_wait = acc && !i_hwrite;
      if (acc)
        next_st.addr = {i_haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st <= '0;
      st.ovr_cfg <= `EOS_RST_OVR_CFG; // [RULE_07]
      st.ovr_ars <= `EOS_RST_OVR_ARS;
      st.ctrl_opt <= `EOS_RST_CTRL_OPT;
      st.key_q <= 1'b1;
      st.mode <= EOS_MODE_READY;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_hreadyout = !(st.dph_rd && st.rd_wait);
  assign o_hresp = 1'b0;
  assign o_hrdata = st.hrdata;
  assign o_override_alarm = st.alarm;
  assign o_override_digital_output = st.override; // [RULE_04]
  assign o_operating_mode_status = st.mode;
  assign o_fault_active = st.fault;
  assign o_fault_autoreset = ar_done;
  assign o_run_enable = st.run;
  assign o_pulse_enable = st.run && !st.fault &&
    !(st.override && st.ovr_cfg == `EOS_CFG_COAST); // [RULE_10]
  assign o_speed_reference = st.speed;
  assign o_switching_frequency = st.swf;
  assign o_slip_comp_enable = !(i_regenerating && !st.ctrl_opt[`EOS_OPT_SLIP]); // [RULE_14]
  assign o_dead_time_comp_enable = st.ctrl_opt[`EOS_OPT_DEADTIME]; // [RULE_15]
  assign o_current_stab_enable = st.ctrl_opt[`EOS_OPT_STAB]; // [RULE_16]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_enter;
    @(posedge i_clk_sys) disable iff (i_reset)
    cfg_active(st.ovr_cfg) && !ovr_in_s |=> st.override && o_override_digital_output;
  endproperty
  a_enter: assert property (p_enter) else $error("override not entered"); // [RULE_01]

  property p_entry_alarm;
    @(posedge i_clk_sys) disable iff (i_reset)
    $rose(st.override) |-> st.alarm && o_operating_mode_status == `EOS_MODE_OVERRIDE;
  endproperty
  a_entry_alarm: assert property (p_entry_alarm) else $error("entry lacks alarm"); // [RULE_02]

  property p_key_clear;
    @(posedge i_clk_sys) disable iff (i_reset)
    st.override && ovr_req && key_edge |=> !st.alarm &&
      o_operating_mode_status == `EOS_MODE_OVERRIDE;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("key did not clear alarm"); // [RULE_03]

  property p_stop_ignored;
    @(posedge i_clk_sys) disable iff (i_reset)
    st.override && st.run && ovr_req |=> st.run && st.override;
  endproperty
  a_stop_ignored: assert property (p_stop_ignored) else $error("stop acted in override"); // [RULE_05]

  property p_off_cfg;
    @(posedge i_clk_sys) disable iff (i_reset)
    !cfg_active(st.ovr_cfg) |=> !st.override;
  endproperty
  a_off_cfg: assert property (p_off_cfg) else $error("override with inactive cfg"); // [RULE_07]

  property p_maxref;
    @(posedge i_clk_sys) disable iff (i_reset)
    ovr_req && st.ovr_cfg == `EOS_CFG_MAXREF |=>
      o_speed_reference == $past(i_maximum_frequency_limit);
  endproperty
  a_maxref: assert property (p_maxref) else $error("speed not forced to max"); // [RULE_09]

  property p_coast;
    @(posedge i_clk_sys) disable iff (i_reset)
    st.override && st.ovr_cfg == `EOS_CFG_COAST |-> !o_pulse_enable;
  endproperty
  a_coast: assert property (p_coast) else $error("pulses on in coast override"); // [RULE_10]

  property p_crit_fault;
    @(posedge i_clk_sys) disable iff (i_reset)
    i_overcurrent_short_fault |=> o_fault_active && !o_pulse_enable;
  endproperty
  a_crit_fault: assert property (p_crit_fault) else $error("critical fault ignored"); // [RULE_06]

  property p_unlimited;
    @(posedge i_clk_sys) disable iff (i_reset)
    ar_done && st.override && !crit |=> !st.fault;
  endproperty
  a_unlimited: assert property (p_unlimited) else $error("auto-reset did not clear"); // [RULE_12]

  property p_limited;
    @(posedge i_clk_sys) disable iff (i_reset)
    st.override && st.fault && st.ovr_ars != `EOS_ARS_UNLIMITED &&
      !i_general_autoreset_setting |=> st.fault;
  endproperty
  a_limited: assert property (p_limited) else $error("fault cleared without permission"); // [RULE_11]

  property p_slip;
    @(posedge i_clk_sys) disable iff (i_reset)
    i_regenerating && !st.ctrl_opt[`EOS_OPT_SLIP] |-> !o_slip_comp_enable;
  endproperty
  a_slip: assert property (p_slip) else $error("slip comp on in regeneration"); // [RULE_14]

  property p_priority;
    @(posedge i_clk_sys) disable iff (i_reset)
    i_current_read_freq_reduction |=> o_switching_frequency == $past(i_current_read_frequency);
  endproperty
  a_priority: assert property (p_priority) else $error("thermal beat current reading"); // [RULE_18]
endmodule // eos_supervisor

// [dv/eos_io_model.sv]
// ----------------------------------------------------------------
// far side model: override input, keypad and command pins
// ----------------------------------------------------------------
// assumes: bench commands the pins by level; pins change after i_clk_sys edges
`timescale 1ns/1ps
module eos_io_model
(
  input wire logic i_clk_sys,
  input wire logic i_open,
  input wire logic i_press,
  input wire logic i_enable,
  input wire logic i_run,
  output logic o_override_digital_input,
  output logic o_operator_key,
  output logic o_general_enable,
  output logic o_run_command
);
  initial
  begin
    o_override_digital_input = 1'b1;
    o_operator_key = 1'b0;
    o_general_enable = 1'b0;
    o_run_command = 1'b0;
  end
  // an opened contact reads as logic zero at the input
  always @(posedge i_clk_sys)
  begin
    o_override_digital_input <= !i_open;
    o_operator_key <= i_press;
    o_general_enable <= i_enable;
    o_run_command <= i_run;
  end
endmodule // eos_io_model

// [dv/test_emergency_override_supervisor.sv]
// ----------------------------------------------------------------
// self-checking bench of the override supervisor
// ----------------------------------------------------------------
// assumes: one AHB-Lite slave, hready is the slave's hreadyout
`timescale 1ns/1ps
`include "eos_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_emergency_override_supervisor
  import eos_pkg::*;
;
  localparam logic [`EOS_TMR_W-1:0] AR = 20;
  logic clk, rst, hsel, hwrite, open_c, press, en, run, ovf, ocf, oth, frst, gar, regen, crr;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] sref, fmax;
  logic [7:0] swf, swmin, temp, ta, tf, crf;
  logic hrdy, hresp, alarm, dout, fault, fars, runen, pulse, slip, dead, stab;
  logic [3:0] mode;
  logic [15:0] oref;
  logic [7:0] oswf;
  logic di, key, gen, runc;
  int error_cnt = 0;
  int check_count = 0;
  eos_io_model io (.i_clk_sys(clk), .i_open(open_c), .i_press(press), .i_enable(en),
    .i_run(run), .o_override_digital_input(di), .o_operator_key(key),
    .o_general_enable(gen), .o_run_command(runc));
  eos_supervisor #(.AUTORESET_CYCLES(AR)) dut (.i_clk_sys(clk), .i_reset(rst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_override_digital_input(di),
    .i_operator_key(key), .i_general_enable(gen), .i_run_command(runc),
    .i_dc_link_overvoltage_fault(ovf), .i_overcurrent_short_fault(ocf),
    .i_other_fault(oth), .i_fault_reset(frst), .i_general_autoreset_setting(gar),
    .i_regenerating(regen), .i_speed_reference(sref), .i_maximum_frequency_limit(fmax),
    .i_switching_frequency_setting(swf), .i_minimum_switching_frequency(swmin),
    .i_temperature(temp), .i_overtemperature_alarm(ta), .i_overtemperature_fault(tf),
    .i_current_read_freq_reduction(crr), .i_current_read_frequency(crf),
    .o_override_alarm(alarm), .o_override_digital_output(dout),
    .o_operating_mode_status(mode), .o_fault_active(fault), .o_fault_autoreset(fars),
    .o_run_enable(runen), .o_pulse_enable(pulse), .o_speed_reference(oref),
    .o_switching_frequency(oswf), .o_slip_comp_enable(slip),
    .o_dead_time_comp_enable(dead), .o_current_stab_enable(stab));

  // ----------------------------------------------------------------
  // bus and timing helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #2 clk = !clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // hready and read data are taken at the rising edge, before the slave updates
  task automatic wait_rdy();
    do
    begin
      @(posedge clk);
    end
    while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map();
    ahb(0, 32'h00, 0);
    `CHK(rd, 32'h0)
    ahb(0, 32'h04, 0);
    `CHK(rd, 32'h0)
    ahb(0, 32'h08, 0);
    `CHK(rd, 32'hB)
    ahb(0, 32'h40, 0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
  endtask
  task automatic t_cfg_modes();
    logic act;
    for (int c = 0; c <= 4; c++)
    begin
      act = (c == 1 || c == 2 || c == 4);
      ahb(1, 32'h00, c);
      open_c <= 1;
      tick(4);
      `CHK(dout, 1'b0)
      tick(2);
      `CHK(dout, act)
      `CHK(alarm, act)
      `CHK(mode == 4'h3, act)
      `CHK(oref, (c == 2) ? fmax : sref)
      `CHK(pulse, c != 4)
      open_c <= 0;
      tick(6);
      `CHK(dout, 1'b0)
    end
  endtask
  task automatic t_key_stop();
    ahb(1, 32'h00, 1);
    open_c <= 1;
    tick(6);
    ahb(0, 32'h0C, 0);
    `CHK(rd[5:0], 6'h33)
    press <= 1;
    tick(6);
    `CHK(alarm, 1'b0)
    `CHK(mode, 4'h3)
    en <= 0;
    run <= 0;
    tick(6);
    `CHK(runen, 1'b1)
    press <= 0;
  endtask
  task automatic t_faults();
    int n;
    ahb(1, 32'h04, 1);
    ovf <= 1;
    tick(1);
    ovf <= 0;
    tick(10);
    `CHK(fault, 1'b1)
    `CHK(pulse, 1'b0)
    n = 11;
    while (n < 60)
    begin
      @(negedge clk);
      if (fars === 1'b1)
        break;
      @(posedge clk);
      n++;
    end
    `CHK(n >= AR - 2 && n <= AR + 3, 1'b1)
    tick(3);
    `CHK(fault, 1'b0)
    ahb(1, 32'h04, 0);
    ocf <= 1;
    tick(1);
    ocf <= 0;
    tick(2 * AR);
    `CHK(fault, 1'b1)
    gar <= 1;
    tick(1);
    gar <= 0;
    tick(3);
    `CHK(fault, 1'b0)
    open_c <= 0;
    tick(6);
  endtask
  task automatic t_options();
    regen <= 1;
    for (int v = 0; v < 16; v++)
    begin
      ahb(1, 32'h08, v);
      ahb(0, 32'h08, 0);
      `CHK(rd, 32'(v))
      `CHK(slip, v[0])
      `CHK(dead, v[1])
      `CHK(stab, v[2])
    end
    ahb(1, 32'h08, 32'h1F);
    ahb(0, 32'h08, 0);
    `CHK(rd, 32'hF)
    ahb(1, 32'h08, 32'hB);
    regen <= 0;
  endtask
  task automatic t_thermal();
    logic [7:0] tt [4] = '{8'd90, 8'd150, 8'd200, 8'd150};
    logic [7:0] ex [4] = '{8'd16, 8'd10, 8'd4, 8'd7};
    for (int i = 0; i < 4; i++)
    begin
      temp <= tt[i];
      crr <= (i == 3);
      tick(3);
      `CHK(oswf, ex[i])
    end
    crr <= 0;
    temp <= 8'd200;
    ahb(1, 32'h08, 32'h3);
    tick(3);
    `CHK(oswf, 8'd16)
    ahb(1, 32'h08, 32'hB);
  endtask

  initial
  begin
    rst = 1;
    {hsel, hwrite, open_c, press, ovf, ocf, oth, frst, gar, regen, crr} = '0;
    en = 1;
    run = 1;
    htrans = 0;
    haddr = 0;
    hwdata = 0;
    sref = 16'h0123;
    fmax = 16'h0FA0;
    swf = 8'd16;
    swmin = 8'd4;
    temp = 8'd90;
    ta = 8'd100;
    tf = 8'd200;
    crf = 8'd7;
    tick(20);
    rst <= 0;
    t_reset_map();
    t_cfg_modes();
    t_key_stop();
    t_faults();
    t_options();
    t_thermal();
    summarize();
  end
  // a hung handshake ends the run through the same verdict
  initial
  begin
    tick(20000);
    error_cnt++;
    summarize();
  end
endmodule // test_emergency_override_supervisor
